/* logic/flash_host.v */
// Host controller that runs read and write cycles on a byte-wide NOR flash.
// Assumes the flash sits on the pins below and times its own operations;
// a user issues one request at a time through the req/ack ports.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_map.vh"
// Behaviour
// - Host drives full 19-bit byte address.
// - Controls decode read, write or float.
// - Commands are ordinary host write cycles.
// - Host polls bit 6 and bit 2.
// - Address bits 18..16 select the sector.
module flash_host (
  input wire sys_clk,
  input wire rstn,
  input wire req,
  input wire req_write,
  input wire req_poll,
  input wire [`ADDR_W-1:0] req_addr,
  input wire [`DATA_W-1:0] req_wdata,
  output reg ack,
  output reg [`DATA_W-1:0] rdata,
  output reg op_done,
  output reg erase_target,
  output reg [2:0] sector,
  output reg [`ADDR_W-1:0] byte_address_bus,
  output reg [`DATA_W-1:0] byte_data_bus_o,
  output reg byte_data_bus_oe,
  input wire [`DATA_W-1:0] byte_data_bus_i,
  output reg select_n,
  output reg write_n,
  output reg gate_n
);
  // Controller states; binary codes, one idle home state.
  localparam [2:0] ST_IDLE = 3'h0; // Waiting for a request.
  localparam [2:0] ST_RD = 3'h1; // First or only read access.
  localparam [2:0] ST_WSET = 3'h2; // Address and data setup.
  localparam [2:0] ST_WPUL = 3'h3; // Write strobe low.
  localparam [2:0] ST_WHLD = 3'h4; // Data hold after the strobe.
  localparam [2:0] ST_PRD1 = 3'h5; // Gap cycle between poll reads.
  localparam [2:0] ST_PRD2 = 3'h6; // Second read of a poll pair.
  localparam [2:0] ST_DONE = 3'h7; // Acknowledge the request.
  // Cycle budget for a read includes two synchroniser stages, since the
  // returned byte is only seen two edges after it settles on the pins.
  localparam integer RD_CYC_I = `ACC_CYC + 2;
  localparam integer WP_CYC_I = `WPW_CYC;
  localparam integer SU_CYC_I = `SETUP_CYC;
  // The counter is four bits wide; the budgets are cut to it on purpose.
  localparam [3:0] RD_CYC = RD_CYC_I[3:0];
  localparam [3:0] WP_CYC = WP_CYC_I[3:0];
  localparam [3:0] SU_CYC = SU_CYC_I[3:0];
  // Present state of the sequencer.
  reg [2:0] state_r;
  // Counts cycles inside a timed phase; cleared when a phase begins.
  reg [3:0] cnt_r;
  reg poll_r; // Set while the request is a status poll pair.
  reg [`DATA_W-1:0] first_r; // First status byte of a poll pair.
  wire [`DATA_W-1:0] data_sync; // Data bus after two flip-flops.
  // Returned byte crosses into sys_clk through two flip-flops.
  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din(byte_data_bus_i),
    .dout(data_sync)
  );
  // Sector number carried by a byte address.
  function [2:0] sect_of;
    input [`ADDR_W-1:0] a;
    begin
      sect_of = a[`SECT_HI:`SECT_LO];
    end
  endfunction
  // Two reads differ in a toggle position while the flash is busy.
  function toggled;
    input [`DATA_W-1:0] x;
    input [`DATA_W-1:0] y;
    input integer b;
    begin
      toggled = x[b] ^ y[b];
    end
  endfunction
  // Main sequencer; all pins stay deselected and idle out of reset,
  // so the flash remains in array-read standby until asked.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // Reset loads constants only, on every register.
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      poll_r <= 1'b0;
      first_r <= `RST_DATA;
      ack <= 1'b0;
      rdata <= `RST_DATA;
      op_done <= 1'b0;
      erase_target <= 1'b0;
      sector <= 3'h0;
      byte_address_bus <= `RST_ADDR;
      byte_data_bus_o <= `RST_DATA;
      byte_data_bus_oe <= 1'b0;
      select_n <= 1'b1;
      write_n <= 1'b1;
      gate_n <= 1'b1;
    end else begin
      // Acknowledge is a pulse; it drops on every edge unless set below.
      ack <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Requests are only taken here; others are ignored while busy.
          if (req) begin
            // Full address is driven for every access.
            byte_address_bus <= req_addr;
            // Address bits 18 to 16 give the sector for the caller.
            sector <= sect_of(req_addr);
            poll_r <= req_poll;
            cnt_r <= 4'h0;
            select_n <= 1'b0;
            if (req_write) begin
              // Commands and program data are plain write cycles; the
              // flash latches them at the strobe edges.
              byte_data_bus_o <= req_wdata;
              byte_data_bus_oe <= 1'b1;
              gate_n <= 1'b1;
              state_r <= ST_WSET;
            end else begin
              // Read: gate low and strobe high, our drivers released.
              byte_data_bus_oe <= 1'b0;
              write_n <= 1'b1;
              gate_n <= 1'b0;
              state_r <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (cnt_r == RD_CYC - 4'h1) begin
            // Deselect between the two status reads so each is a cycle.
            select_n <= 1'b1;
            gate_n <= 1'b1;
            cnt_r <= 4'h0;
            if (poll_r) begin
              first_r <= data_sync;
              state_r <= ST_PRD1;
            end else begin
              rdata <= data_sync;
              state_r <= ST_DONE;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_WSET: begin
          // Address and data settle before the strobe falls.
          if (cnt_r == SU_CYC - 4'h1) begin
            write_n <= 1'b0;
            cnt_r <= 4'h0;
            state_r <= ST_WPUL;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_WPUL: begin
          // Strobe width counts here; the flash latches data on its rise.
          if (cnt_r == WP_CYC - 4'h1) begin
            write_n <= 1'b1;
            state_r <= ST_WHLD;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_WHLD: begin
          // Data is held one cycle past the rising strobe.
          select_n <= 1'b1;
          byte_data_bus_oe <= 1'b0;
          state_r <= ST_DONE;
        end
        ST_PRD1: begin
          // Second read of the status byte for toggle comparison.
          select_n <= 1'b0;
          gate_n <= 1'b0;
          state_r <= ST_PRD2;
        end
        ST_PRD2: begin
          // Same access length as the first read so both bytes are valid.
          if (cnt_r == RD_CYC - 4'h1) begin
            select_n <= 1'b1;
            gate_n <= 1'b1;
            rdata <= data_sync;
            // Steady toggle bit means the embedded operation ended and
            // the flash is back in read mode.
            op_done <= ~toggled(first_r, data_sync, `TOGGLE_BIT);
            // Bit 2 toggling marks a sector chosen for erase.
            erase_target <= toggled(first_r, data_sync, `ETGT_BIT);
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_DONE: begin
          // One-cycle acknowledge, then back to idle for the next request.
          ack <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          // Unused codes cannot occur, but recover to idle if they do.
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* logic/flash_host_map.vh */
// Constants for the parallel NOR flash host controller.
// Assumes inclusion by bare name from design files of this block.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// Address and data widths of the external flash.
`define ADDR_W 19
`define DATA_W 8
// Sector field position within the byte address.
`define SECT_HI 18
`define SECT_LO 16
// Status bit positions in the polled byte.
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define ETGT_BIT 2
// Bus timing in nanoseconds and the clock period.
`define CLK_NS 50
`define ACC_NS 90
`define WPW_NS 50
`define SETUP_NS 50
// Derived cycle counts; least times round up.
`define ACC_CYC ((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WPW_CYC ((`WPW_NS + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
// Reset values.
`define RST_DATA 8'h00
`define RST_ADDR 19'h00000
`endif

/* logic/pin_sync.v */
// Two flip-flop synchroniser for the byte data bus returned by the flash.
// Assumes the flash drives the bus asynchronously to sys_clk.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_map.vh"
module pin_sync (
  input wire sys_clk,
  input wire rstn,
  input wire [`DATA_W-1:0] din,
  output reg [`DATA_W-1:0] dout
);
  // First stage; read only by the second stage.
  reg [`DATA_W-1:0] meta_r;
  // Both stages reset to a constant so no port value enters reset.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= `RST_DATA;
      dout <= `RST_DATA;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* test/flash_host_asserts.sv */
// Pin checks for the flash host controller.
// Assumes a bind onto flash_host from the bench.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_map.vh"
module flash_host_asserts (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ack,
  input wire logic [`ADDR_W-1:0] byte_address_bus,
  input wire logic byte_data_bus_oe,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic gate_n
);
  // One clock domain, so defaults serve every check.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_no_fight: assert property (!write_n |-> gate_n)
    else $error("write and gate low together");
  a_write_drive: assert property (!write_n |->
    byte_data_bus_oe && !select_n)
    else $error("write without drive or select");
  a_read_float: assert property (!gate_n |-> !byte_data_bus_oe && write_n)
    else $error("drive during read");
  a_idle_float: assert property (select_n |-> !byte_data_bus_oe && gate_n)
    else $error("drive while deselected");
  a_addr_hold: assert property (!select_n && $past(!select_n)
    |-> $stable(byte_address_bus))
    else $error("address moved in a cycle");
  a_write_pulse: assert property ($fell(write_n)
    |=> write_n && !select_n ##1 select_n)
    else $error("bad write pulse or hold");
  a_read_access: assert property ($fell(gate_n)
    |-> !gate_n [*4] ##1 gate_n)
    else $error("bad read access length");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than a cycle");
endmodule
`default_nettype wire

/* test/flash_host_bench.sv */
// Self-checking bench for flash_host with a flash model.
// Assumes the design files compile first.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_map.vh"
module flash_host_bench;
  logic sys_clk = 0, rstn = 0, req = 0, req_write = 0, req_poll = 0;
  logic [`ADDR_W-1:0] req_addr = 19'h00000;
  logic [`DATA_W-1:0] req_wdata = 8'h00;
  wire ack, op_done, erase_target, oe, select_n, write_n, gate_n;
  wire [7:0] rdata, dq_o, dq_m, dq;
  wire [2:0] sector;
  wire [18:0] addr;
  int fail_count = 0, n_compared = 0;
  // Command bytes the model acts on; arbitrary stand-in values.
  localparam logic [7:0] ERASE = 8'hE5, SUSP = 8'hB3;
  // The host wins the bus only while it enables its drivers.
  assign dq = oe ? dq_o : dq_m;
  flash_host dut (.sys_clk, .rstn, .req, .req_write, .req_poll,
    .req_addr, .req_wdata, .ack, .rdata, .op_done, .erase_target,
    .sector, .byte_address_bus(addr), .byte_data_bus_o(dq_o),
    .byte_data_bus_oe(oe), .byte_data_bus_i(dq), .select_n,
    .write_n, .gate_n);
  flash_model #(.ERASE_CODE(ERASE), .SUSP_CODE(SUSP)) mem (.addr,
    .din(dq_o), .select_n, .write_n, .gate_n, .dout(dq_m));
  initial forever #25 sys_clk = ~sys_clk;
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string n, input logic [18:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %0h seen %0h", n, e, s);
    end
  endtask
  // One request, held for a single cycle, then a bounded wait for ack.
  task go(input logic w, p, input logic [18:0] a, input logic [7:0] d);
    int i;
    @(negedge sys_clk);
    {req, req_write, req_poll, req_addr, req_wdata} = {1'h1, w, p, a, d};
    @(negedge sys_clk);
    req = 0;
    for (i = 0; i < 30 && ack !== 1'h1; i++) @(negedge sys_clk);
    if (ack !== 1'h1) begin
      fail_count++;
      complete_run();
    end
  endtask
  task t_reset;
    check("idle pins", {select_n, write_n, gate_n, oe}, 4'hE);
  endtask
  task t_blank;
    go(0, 0, 19'h1ABCD, 8'h00);
    check("blank read", rdata, 8'hFF);
    check("sector", sector, 3'h1);
  endtask
  // Program, poll while busy, then poll and read after completion.
  task t_program;
    go(1, 0, 19'h20010, 8'h5A);
    go(0, 1, 19'h20010, 8'h00);
    check("busy poll", op_done, 1'h0);
    check("no erase", erase_target, 1'h0);
    repeat (80) @(negedge sys_clk);
    go(0, 1, 19'h20010, 8'h00);
    check("done poll", op_done, 1'h1);
    go(0, 0, 19'h20010, 8'h00);
    check("program", rdata, 8'h5A);
    go(0, 0, 19'h20011, 8'h00);
    check("neighbour", rdata, 8'hFF);
  endtask
  // A write into the protected top sector leaves it erased.
  task t_protect;
    go(1, 0, 19'h7FFFF, 8'h12);
    go(0, 1, 19'h7FFFF, 8'h00);
    check("prot poll", op_done, 1'h1);
    go(0, 0, 19'h7FFFF, 8'h00);
    check("prot read", rdata, 8'hFF);
    check("top sector", sector, 3'h7);
  endtask
  // Erase sector 2 with a suspend in the middle; sector 3 keeps its byte.
  task t_erase;
    go(1, 0, 19'h30020, 8'h3C);
    repeat (80) @(negedge sys_clk);
    go(1, 0, 19'h20000, ERASE);
    go(0, 1, 19'h20010, 8'h00);
    check("erase busy", op_done, 1'h0);
    check("erase sector", erase_target, 1'h1);
    go(0, 1, 19'h30020, 8'h00);
    check("other sector", erase_target, 1'h0);
    go(1, 0, 19'h20000, SUSP);
    go(0, 0, 19'h30020, 8'h00);
    check("suspend read", rdata, 8'h3C);
    go(1, 0, 19'h20000, SUSP);
    repeat (100) @(negedge sys_clk);
    go(0, 1, 19'h20010, 8'h00);
    check("erase done", op_done, 1'h1);
    go(0, 0, 19'h20010, 8'h00);
    check("erased", rdata, 8'hFF);
    go(0, 0, 19'h30020, 8'h00);
    check("kept", rdata, 8'h3C);
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    t_reset();
    rstn = 1;
    t_blank();
    t_program();
    t_protect();
    t_erase();
    complete_run();
  end
endmodule
bind flash_host flash_host_asserts chk (.sys_clk, .rstn, .ack,
  .byte_address_bus, .byte_data_bus_oe, .select_n, .write_n, .gate_n);
`default_nettype wire

/* test/flash_model.sv */
// Behavioural byte-wide flash on the host pins.
// Assumes the bench merges its output with the host drive.
`timescale 1ns/1ns
`default_nettype none
module flash_model #(parameter int BUSY_NS = 3000,
  parameter logic [7:0] PROT = 8'h80,
  parameter logic [7:0] ERASE_CODE = 8'hE5,
  parameter logic [7:0] SUSP_CODE = 8'hB3) (
  input wire logic [18:0] addr,
  input wire logic [7:0] din,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic gate_n,
  output logic [7:0] dout
);
  // The two command bytes are arbitrary stand-ins, not real codes.
  // Sparse array; unwritten bytes read as erased.
  logic [7:0] mem [int];
  logic busy = 0, tog = 0, etog = 0, erasing = 0, susp = 0;
  logic [7:0] ld = 8'h00, last = 8'h00, rd;
  logic [18:0] la = 19'h00000; // Latched address of the running work.
  logic [2:0] es = 3'h0; // Sector under erase.
  event kick;
  wire logic rd_on = !select_n && !gate_n && write_n;
  wire logic in_es = erasing && addr[18:16] == es;
  // Status hides data while busy; a suspended erase shows it only
  // inside its own sector.
  wire logic stat = busy && !susp || susp && in_es;
  // Writes latch into side registers; during a suspend, unprotected bytes outside the erase sector go straight into the array.
  always @(posedge write_n) if (!select_n && gate_n) begin
    if (erasing && din == SUSP_CODE) susp = ~susp;
    else if (susp && addr[18:16] != es && !PROT[addr[18:16]])
      mem[addr] = din;
    else if (!busy && !PROT[addr[18:16]]) begin
      la = addr;
      ld = din;
      -> kick;
    end
  end
  // Self-timed work; an erase runs in steps and stands still while suspended.
  always @kick begin
    busy = 1;
    if (ld == ERASE_CODE) begin
      erasing = 1;
      es = la[18:16];
      foreach (mem[k]) if (k[18:16] == es) mem[k] = 8'h00;
      for (int i = 0; i < BUSY_NS / 50; i++) begin
        #50;
        while (susp) #50;
      end
      foreach (mem[k]) if (k[18:16] == es) mem[k] = 8'hFF;
      erasing = 0;
    end else begin
      #(BUSY_NS) mem[la] = ld;
    end
    busy = 0;
  end
  // Toggle bits flip as each read ends, so the two reads of a poll pair
  // differ while work runs, whatever order the control pins rise in.
  always @(negedge rd_on) begin
    if (busy && !susp) tog = ~tog;
    if (in_es) etog = ~etog;
  end
  always @* rd = stat
    ? {~ld[7] & ~erasing, tog, 3'h0, etog & in_es, 2'h0}
    : mem.exists(addr) ? mem[addr] : 8'hFF;
  // A released bus shows the inverse of the last byte, never a copy.
  always @* if (rd_on) begin
    dout = rd;
    last = rd;
  end else dout = ~last;
endmodule
`default_nettype wire
